/* pbcl_loader.sv */
/*
  pbcl_loader: target-side sequencer for the fast parallel byte load.
  Assumes all pins are asynchronous to clock_i; all but the clock select
  and flag enable are synchronised here; open-drain lines resolve outside from the enable outputs.
*/
// Contract
// - capture one byte per byte-clock rise
// - power-up reset 100 ms low, 12 ms high
// - during power-up: held reset, error line low
// - target 12 ms, source 100 ms recommended
// - release open-drain line after power-up delay
// - weak pull-ups on unless select pin high; here only in reset and configuration
// - stages: reset, configuration, initialization in order
// - stay in reset while restart or error low
// - restart rise leaves reset, releases error line
// - release load-complete after all data received
// - load-complete rise ends config, starts initialization
// - oscillator initialization default, user clock optional
// - user clock: delay, then 299 cycles
// - enable delay at least four byte periods
// - user clock ignored during configuration stage
// - user-mode flag: released, low, then released
// - decompression only in the source
`timescale 1ns/1ns
module pbcl_loader #(
  parameter int unsigned POR_LONG_CYCLES  = pbcl_pkg::POR_LONG_CYC,
  parameter int unsigned POR_SHORT_CYCLES = pbcl_pkg::POR_SHORT_CYC,
  parameter int unsigned LOAD_BYTES       = 64
) (
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic       powerup_delay_select_i,
  input  wire logic       weak_pullup_select_low_i,
  input  wire logic       restart_request_low_i,
  input  wire logic       error_reset_line_i,
  output logic            error_reset_line_oe_o,
  output logic            error_reset_line_o,
  input  wire logic       load_complete_line_i,
  output logic            load_complete_line_oe_o,
  output logic            load_complete_line_o,
  input  wire logic       cfg_byte_clock_i,
  input  wire logic [7:0] cfg_data_i,
  input  wire logic       user_init_clock_i,
  input  wire logic       user_init_clock_sel_i,
  input  wire logic       user_mode_flag_en_i,
  output logic            user_mode_flag_oe_o,
  output logic            user_mode_flag_o,
  output logic            user_io_hiz_o,
  output logic            weak_pullup_en_o,
  output logic            cfg_byte_valid_o,
  input  wire logic       cfg_byte_ready_i,
  output logic      [7:0] cfg_byte_o,
  output logic            user_mode_o
);
  // local widths keep the casts short
  localparam int unsigned CW    = pbcl_pkg::CNT_W;
  localparam int unsigned PIN_W = 15;
  localparam int unsigned EW    = 9;

  // raw pin bundle and its two-flop synchroniser
  logic [PIN_W-1:0]      pin_raw;
  logic [PIN_W-1:0]      pin_meta_reg;
  logic [PIN_W-1:0]      pin_sync_reg;

  // synchronised views of the pins
  logic                  por_short_s;
  logic                  pullup_off_s;
  logic                  restart_high_s;
  logic                  err_line_s;
  logic                  done_line_s;
  logic                  byte_clk_s;
  logic                  user_clk_s;
  logic [7:0]            data_s;

  // edge detectors on the slow pin clocks and the load-complete line
  logic                  byte_clk_prev_reg;
  logic                  user_clk_prev_reg;
  logic                  done_prev_reg;
  logic                  byte_rise;
  logic                  user_rise;
  logic                  done_rise;

  // sequencer state and counters
  pbcl_pkg::pbcl_state_t state_reg;
  pbcl_pkg::pbcl_state_t state_next;
  logic [CW-1:0]         cnt_reg;
  logic [CW-1:0]         byte_cnt_reg;
  logic [EW-1:0]         user_edges_reg;
  logic                  cnt_run;
  logic [CW-1:0]         por_last;
  logic                  por_done;
  logic                  user_clk_on;
  logic                  init_osc_done;
  logic                  init_user_done;
  logic                  init_done;

  // capture path
  logic                  take_byte;
  logic                  last_byte;
  logic                  fifo_in_ready;
  logic                  fifo_flush;
  logic                  done_rel_reg;
  logic                  lost_byte_reg;
  logic                  flag_arm_reg;

  // every pin but the clock select and flag enable, data bus included, enters here
  assign pin_raw = {cfg_data_i, user_init_clock_i, cfg_byte_clock_i, load_complete_line_i,
                    error_reset_line_i, restart_request_low_i, weak_pullup_select_low_i,
                    powerup_delay_select_i};

  // data and byte clock share the same two stages, so data is
  // already settled when the synchronised clock shows its rise
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          pin_meta_reg[gi] <= 1'b0;
          pin_sync_reg[gi] <= 1'b0;
        end else begin
          pin_meta_reg[gi] <= pin_raw[gi];
          pin_sync_reg[gi] <= pin_meta_reg[gi];
        end
      end
    end
  endgenerate

  // named taps of the second stage only
  assign por_short_s    = pin_sync_reg[0];
  assign pullup_off_s   = pin_sync_reg[1];
  assign restart_high_s = pin_sync_reg[2];
  assign err_line_s     = pin_sync_reg[3];
  assign done_line_s    = pin_sync_reg[4];
  assign byte_clk_s     = pin_sync_reg[5];
  assign user_clk_s     = pin_sync_reg[6];
  assign data_s         = pin_sync_reg[14:7];

  // previous values reset to the idle level of each line, so no
  // false edge follows reset
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      byte_clk_prev_reg <= 1'b0;
      user_clk_prev_reg <= 1'b0;
      done_prev_reg     <= 1'b0;
    end else begin
      byte_clk_prev_reg <= byte_clk_s;
      user_clk_prev_reg <= user_clk_s;
      done_prev_reg     <= done_line_s;
    end
  end

  // rising edges; the core clock must run well above either pin clock
  assign byte_rise = byte_clk_s & ~byte_clk_prev_reg;
  assign user_rise = user_clk_s & ~user_clk_prev_reg;
  assign done_rise = done_line_s & ~done_prev_reg;

  // power-up stretch: select high picks the short delay
  assign por_last = por_short_s ? CW'(POR_SHORT_CYCLES - 1) : CW'(POR_LONG_CYCLES - 1);
  assign por_done = (cnt_reg >= por_last); // tolerates a late select change

  // initialization ends on the oscillator count or the user clock count
  assign init_osc_done  = (cnt_reg == CW'(pbcl_pkg::OSC_INIT_CYC - 1));
  assign user_clk_on    = (cnt_reg == CW'(pbcl_pkg::USER_CLK_DELAY_CYC));
  assign init_user_done = user_clk_on && (user_edges_reg == EW'(pbcl_pkg::USER_INIT_EDGES));
  assign init_done      = user_init_clock_sel_i ? init_user_done : init_osc_done;

  // state register
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= pbcl_pkg::PBCL_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  // stage order: power-up, reset, configuration, initialization, user
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pbcl_pkg::PBCL_POR: begin
        if (por_done) begin
          state_next = pbcl_pkg::PBCL_RST;
        end
      end
      pbcl_pkg::PBCL_RST: begin
        // restart and the shared error line must both be high
        if (restart_high_s && err_line_s) begin
          state_next = pbcl_pkg::PBCL_CFG;
        end
      end
      pbcl_pkg::PBCL_CFG: begin
        if (!restart_high_s || !err_line_s) begin
          state_next = pbcl_pkg::PBCL_RST;
        end else if (done_rel_reg && done_rise) begin
          state_next = pbcl_pkg::PBCL_INIT;
        end
      end
      pbcl_pkg::PBCL_INIT: begin
        if (!restart_high_s) begin
          state_next = pbcl_pkg::PBCL_RST;
        end else if (init_done) begin
          state_next = pbcl_pkg::PBCL_USER;
        end
      end
      pbcl_pkg::PBCL_USER: begin
        if (!restart_high_s) begin
          state_next = pbcl_pkg::PBCL_RST;
        end
      end
      default: begin
        state_next = pbcl_pkg::PBCL_POR;
      end
    endcase
  end

  // shared counter: power-up stretch, then initialization time;
  // in user clock mode it parks at the enable delay
  assign cnt_run = (state_reg == pbcl_pkg::PBCL_POR) ||
                   ((state_reg == pbcl_pkg::PBCL_INIT) &&
                    !(user_init_clock_sel_i && user_clk_on));

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= pbcl_pkg::CNT_RESET;
    end else if (state_next != state_reg) begin
      cnt_reg <= pbcl_pkg::CNT_RESET;
    end else if (cnt_run) begin
      cnt_reg <= CW'(cnt_reg + 1'b1);
    end
  end

  // user clock edges count only in initialization after the delay
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      user_edges_reg <= '0;
    end else if (state_reg != pbcl_pkg::PBCL_INIT) begin
      user_edges_reg <= '0;
    end else if (user_init_clock_sel_i && user_clk_on && user_rise && !init_user_done) begin
      user_edges_reg <= EW'(user_edges_reg + 1'b1);
    end
  end

  // byte strobe: only in configuration, only until the clean last byte
  assign take_byte = (state_reg == pbcl_pkg::PBCL_CFG) && byte_rise && !done_rel_reg;
  assign last_byte = take_byte && (byte_cnt_reg == CW'(LOAD_BYTES - 1));

  // byte counter
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      byte_cnt_reg <= pbcl_pkg::CNT_RESET;
    end else if (state_reg == pbcl_pkg::PBCL_RST) begin
      byte_cnt_reg <= pbcl_pkg::CNT_RESET;
    end else if (take_byte) begin
      byte_cnt_reg <= CW'(byte_cnt_reg + 1'b1);
    end
  end

  // a byte refused by a full fifo is lost; the load then never
  // completes, since error recovery is outside this block
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lost_byte_reg <= 1'b0;
    end else if (state_reg == pbcl_pkg::PBCL_RST) begin
      lost_byte_reg <= 1'b0;
    end else if (take_byte && !fifo_in_ready) begin
      lost_byte_reg <= 1'b1;
    end
  end

  // release of the load-complete line after a clean last byte
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_rel_reg <= 1'b0;
    end else if (state_reg == pbcl_pkg::PBCL_RST) begin
      done_rel_reg <= 1'b0;
    end else if (last_byte && fifo_in_ready && !lost_byte_reg) begin
      done_rel_reg <= 1'b1;
    end
  end

  // flag enable bit rides in the first byte of the frame
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_arm_reg <= 1'b0;
    end else if (state_reg == pbcl_pkg::PBCL_RST) begin
      flag_arm_reg <= 1'b0;
    end else if (take_byte && (byte_cnt_reg == pbcl_pkg::CNT_RESET)) begin
      flag_arm_reg <= data_s[pbcl_pkg::FLAG_EN_BIT] & user_mode_flag_en_i;
    end
  end

  // fifo is emptied in reset so a restart never replays old bytes
  assign fifo_flush = (state_reg == pbcl_pkg::PBCL_RST);

  // bytes pass through unchanged: no decompression here
  pbcl_fifo #(
    .WIDTH (pbcl_pkg::FIFO_W),
    .DEPTH (pbcl_pkg::FIFO_D)
  ) u_fifo (
    .clock_i     (clock_i),
    .rst_b_i     (rst_b_i),
    .flush_i     (fifo_flush),
    .in_valid_i  (take_byte),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (data_s),
    .out_valid_o (cfg_byte_valid_o),
    .out_ready_i (cfg_byte_ready_i),
    .out_data_o  (cfg_byte_o)
  );

  // error line: pulled in power-up and while restart is requested
  assign error_reset_line_oe_o = (state_reg == pbcl_pkg::PBCL_POR) ||
                                 ((state_reg == pbcl_pkg::PBCL_RST) &&
                                  !restart_high_s);
  assign error_reset_line_o    = 1'b0;

  // load-complete line: low until the clean last byte
  assign load_complete_line_oe_o = (state_reg == pbcl_pkg::PBCL_POR) ||
                                   (state_reg == pbcl_pkg::PBCL_RST) ||
                                   ((state_reg == pbcl_pkg::PBCL_CFG) && !done_rel_reg);
  assign load_complete_line_o    = 1'b0;

  // flag pulled low from the first frame until user mode
  assign user_mode_flag_oe_o = flag_arm_reg &&
                               ((state_reg == pbcl_pkg::PBCL_CFG) ||
                                (state_reg == pbcl_pkg::PBCL_INIT));
  assign user_mode_flag_o    = 1'b0;

  // pins float until user mode; weak pull-ups in reset and configuration only
  assign user_io_hiz_o    = (state_reg != pbcl_pkg::PBCL_USER);
  assign weak_pullup_en_o = !pullup_off_s &&
                            ((state_reg == pbcl_pkg::PBCL_RST) ||
                             (state_reg == pbcl_pkg::PBCL_CFG));
  assign user_mode_o      = (state_reg == pbcl_pkg::PBCL_USER);
endmodule

/* pbcl_pkg.sv */
/*
  pbcl_pkg: constants and state encoding for the parallel byte
  configuration loader. Assumes a 125 MHz core clock.
*/
package pbcl_pkg;

  // core clock
  localparam int unsigned CLK_PERIOD_NS = 8;

  // power-up reset stretch, in ms, and the derived cycle counts
  localparam int unsigned POR_LONG_MS   = 100;
  localparam int unsigned POR_SHORT_MS  = 12;
  localparam int unsigned POR_LONG_CYC  = POR_LONG_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned POR_SHORT_CYC = POR_SHORT_MS * 1000000 / CLK_PERIOD_NS;

  // byte clock limits: longest period in ns, user clock enable delay
  localparam int unsigned BYTE_CLK_MAX_PERIOD_NS = 10;
  localparam int unsigned USER_CLK_DELAY_NS      = 4 * BYTE_CLK_MAX_PERIOD_NS;
  localparam int unsigned USER_CLK_DELAY_CYC     =
    (USER_CLK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // internal oscillator initialization, in core cycles
  localparam int unsigned OSC_INIT_US  = 20;
  localparam int unsigned OSC_INIT_CYC = OSC_INIT_US * 1000 / CLK_PERIOD_NS;

  // user clock initialization edges
  localparam int unsigned USER_INIT_EDGES = 299;

  // counter width and reset values
  localparam int unsigned CNT_W           = 24;
  localparam logic [23:0] CNT_RESET       = 24'h000000;
  localparam logic [7:0]  BYTE_RESET      = 8'h00;

  // position of the user-mode flag enable bit in the first frame byte
  localparam int unsigned FLAG_EN_BIT = 0;

  // fifo shape
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_D = 16;

  typedef enum logic [4:0] {
    PBCL_POR  = 5'h01,
    PBCL_RST  = 5'h02,
    PBCL_CFG  = 5'h04,
    PBCL_INIT = 5'h08,
    PBCL_USER = 5'h10
  } pbcl_state_t;

endpackage

/* pbcl_fifo.sv */
/*
  pbcl_fifo: synchronous fifo with valid/ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
module pbcl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // honest full and empty straight from the count
  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH)); // count is one bit wider than a pointer
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // storage has no reset: contents are only read behind valid
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (flush_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
      end
      if (pop) begin
        rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
      end
      count_reg <= (AW+1)'(count_reg + {AW'(0), push} - {AW'(0), pop});
    end
  end
endmodule

/* pbcl_loader_asserts.sv */
/* port checker for pbcl_loader; assumes pull-ups on the open-drain lines */
`timescale 1ns/1ns
module pbcl_loader_asserts (
  input wire logic clock_i, rst_b_i, restart_request_low_i,
  input wire logic load_complete_line_i, load_complete_line_oe_o,
  input wire logic load_complete_line_o, error_reset_line_oe_o,
  input wire logic error_reset_line_o, user_mode_flag_oe_o, user_mode_flag_o,
  input wire logic user_mode_flag_en_i, user_io_hiz_o, user_mode_o,
  input wire logic weak_pullup_en_o, weak_pullup_select_low_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // open-drain outputs may only pull low
  chk_err_od: assert property (error_reset_line_oe_o |-> !error_reset_line_o)
    else $error("error line driven high");
  chk_done_od: assert property (load_complete_line_oe_o |-> !load_complete_line_o)
    else $error("done line driven high");
  chk_flag_od: assert property (user_mode_flag_oe_o |-> !user_mode_flag_o)
    else $error("flag driven high");
  chk_flag_user: assert property (user_mode_o && user_mode_flag_en_i |-> !user_mode_flag_oe_o)
    else $error("flag held in user mode");
  chk_pull_sel: assert property (weak_pullup_en_o |-> !weak_pullup_select_low_i)
    else $error("pull-ups against select");
  chk_user_io: assert property (user_mode_o |-> !user_io_hiz_o)
    else $error("pins floating in user mode");
  chk_user_late: assert property ($rose(user_mode_o) |-> load_complete_line_i)
    else $error("user mode before done");
  // a restart must pull the done line within a few cycles
  chk_restart_hold: assert property ($fell(restart_request_low_i) |-> ##[1:4] load_complete_line_oe_o)
    else $error("restart ignored");
endmodule
bind pbcl_loader pbcl_loader_asserts u_chk (.*);

/* pbcl_source_model.sv */
/* flash source model; assumes the bench resolves the shared lines */
`timescale 1ns/1ns
module pbcl_source_model #(parameter int POR_NS = 2000) (
  input  wire logic       line_i,
  input  wire logic       sel_low_i,
  output logic            pull_o,
  output logic            clk_o,
  output logic      [7:0] data_o
);
  // own power-up delay holds the line low, then clocks bytes out
  initial begin
    pull_o = 1;
    clk_o = 0;
    data_o = 8'h5a;
    #(POR_NS) pull_o = 0;
    wait (line_i === 1'b1);
    for (int b = 8'ha1; sel_low_i !== 1'b1; b++) begin
      data_o = b[7:0];
      #40 clk_o = 1;
      #40 clk_o = 0;
    end
    forever #40 data_o = ~data_o; // released bus shows no held value
  end
endmodule

/* tb_parallel_byte_config_load.sv */
/* bench for pbcl_loader; needs pbcl_source_model */
`timescale 1ns/1ns
module tb_parallel_byte_config_load;
  logic clock_i, rst_b_i, restart_request_low_i, error_reset_line_i, error_reset_line_oe_o;
  logic error_reset_line_o, load_complete_line_i, load_complete_line_oe_o, load_complete_line_o;
  logic cfg_byte_clock_i, user_mode_flag_oe_o, user_mode_flag_o, cfg_byte_valid_o, pull;
  logic user_io_hiz_o, weak_pullup_en_o, user_mode_o, user_init_clock_i = 1'b0;
  logic powerup_delay_select_i = 1'b1, weak_pullup_select_low_i = 1'b0, cfg_byte_ready_i = 1'b1;
  logic user_init_clock_sel_i = 1'b0, user_mode_flag_en_i = 1'b1;
  logic [7:0] cfg_data_i, cfg_byte_o, got[$];
  int bad_count, checked, n;
  // pull-ups resolve the shared lines
  assign error_reset_line_i = !(error_reset_line_oe_o || pull);
  always_comb load_complete_line_i = !load_complete_line_oe_o;
  pbcl_loader #(.POR_SHORT_CYCLES(20), .LOAD_BYTES(4)) u_dut (.*);
  pbcl_source_model u_src (.line_i(error_reset_line_i), .sel_low_i(load_complete_line_i),
    .pull_o(pull), .clk_o(cfg_byte_clock_i), .data_o(cfg_data_i));
  initial begin
    clock_i = 0;
    forever #4 clock_i = ~clock_i;
  end
  always #5 user_init_clock_i = ~user_init_clock_i;
  always @(posedge clock_i) if (cfg_byte_valid_o) got.push_back(cfg_byte_o);
  task chk(input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // bounded wait; running out ends the run
  task automatic wait_hi(ref logic s);
    for (n = 0; n < 5000 && s !== 1'b1; n++) @(negedge clock_i);
    chk(s, 1'b1);
    if (s !== 1'b1) close_out();
  endtask
  initial begin
    rst_b_i = 0;
    restart_request_low_i = 0;
    repeat (12) @(negedge clock_i);
    rst_b_i = 1;
    repeat (40) @(negedge clock_i);
    chk(load_complete_line_oe_o, 1'b1);
    chk(weak_pullup_en_o, 1'b1);
    chk(user_mode_o, 1'b0);
    restart_request_low_i = 1;
    wait_hi(load_complete_line_i);
    repeat (2) @(negedge clock_i); // last byte leaves the fifo one cycle later
    chk(user_mode_flag_oe_o, 1'b1);
    chk(8'(got.size()), 8'h04);
    foreach (got[i]) chk(got[i], 8'(8'ha1 + i));
    wait_hi(user_mode_o);
    chk(user_io_hiz_o, 1'b0);
    chk(user_mode_flag_oe_o, 1'b0);
    restart_request_low_i = 0;
    repeat (4) @(negedge clock_i);
    chk(load_complete_line_oe_o, 1'b1);
    close_out();
  end
endmodule
